// *** tsf_pkg.sv ***
`default_nettype none
package tsf_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] TSF_REG_RATE = 8'h00;
  localparam logic [7:0] TSF_REG_INV = 8'h04;
  localparam logic [7:0] TSF_REG_CLKC = 8'h08;
  localparam logic [7:0] TSF_REG_STAT = 8'h0C;
  // ==========================================
  // Reset values
  localparam logic [1:0] TSF_RATE_RST = 2'h3;
  localparam logic [7:0] TSF_INV_RST = 8'h00;
  localparam logic [2:0] TSF_EDGE_RST = 3'h0;
  localparam logic [2:0] TSF_FPLOW_RST = 3'h7;
  // ==========================================
  // Field positions
  localparam int TSF_INV_IN_LSB = 0;
  localparam int TSF_INV_OUT_LSB = 4;
  localparam int TSF_CLKC_EDGE_LSB = 0;
  localparam int TSF_CLKC_FPLOW_LSB = 4;
  localparam int TSF_STAT_SEL_LSB = 0;
  localparam int TSF_STAT_ALT1_LSB = 4;
  localparam int TSF_STAT_ALT2_LSB = 6;
  localparam int TSF_STAT_SEEN_LSB = 8;
  localparam int TSF_STAT_ACT_LSB = 12;
  localparam int TSF_STAT_GATE_LSB = 16;
  // ==========================================
  // Rate codes: 0 65.536, 1 32.768, 2 16.384, 3 8.192
  localparam logic [1:0] TSF_RATE_65M = 2'h0;
  localparam logic [1:0] TSF_RATE_32M = 2'h1;
  // Clock edges per 8 kHz frame at each clock rate
  localparam logic [13:0] TSF_EDGES_8M = 14'h0400;
  localparam logic [13:0] TSF_EDGES_16M = 14'h0800;
  localparam logic [13:0] TSF_EDGES_32M = 14'h1000;
  localparam logic [13:0] TSF_EDGES_65M = 14'h2000;
  localparam logic [13:0] TSF_EDGES_MAX = 14'h3FFF;
  // ==========================================
  // Reference tracker status
  typedef struct packed {
    logic edge_p;
    logic frame_p;
    logic [1:0] rate;
    logic rate_ok;
  } tsf_ref_stat_t;
endpackage : tsf_pkg
`default_nettype wire

// *** tsf_ref_tracker.sv ***
`default_nettype none
module tsf_ref_tracker
  import tsf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ref_clk_i,
  input wire logic ref_fp_i,
  input wire logic fall_edge_i,
  input wire logic fp_low_i,
  output tsf_ref_stat_t stat_o
);
  typedef struct packed {
    logic [1:0] clk_s;
    logic [1:0] fp_s;
    logic clk_prev;
    logic fp_prev;
    logic [13:0] cnt;
    logic [2:0] arm;
    tsf_ref_stat_t st;
  } tsf_trk_t;

  tsf_trk_t s_q, s_d;
  logic edge_w, fp_act_w;

  // ==========================================
  // Edge and pulse qualification
  always_comb begin
    s_d = s_q;
    s_d.clk_s = {s_q.clk_s[0], ref_clk_i};
    s_d.fp_s = {s_q.fp_s[0], ref_fp_i};
    s_d.clk_prev = s_q.clk_s[1];
    // No edges until the synchroniser holds real pin samples
    s_d.arm = {s_q.arm[1:0], 1'b1};
    edge_w = s_q.arm[2] & (fall_edge_i ? (s_q.clk_prev & ~s_q.clk_s[1])
                                       : (~s_q.clk_prev & s_q.clk_s[1]));
    fp_act_w = s_q.fp_s[1] ^ fp_low_i;
    s_d.st.edge_p = edge_w;
    s_d.st.frame_p = 1'b0;
    if (edge_w) begin
      s_d.fp_prev = fp_act_w;
      if (s_q.cnt != TSF_EDGES_MAX) begin
        s_d.cnt = s_q.cnt + 14'h0001;
      end
      if (fp_act_w && !s_q.fp_prev) begin
        s_d.st.frame_p = 1'b1;
        s_d.cnt = 14'h0001;
        s_d.st.rate_ok = 1'b1;
        case (s_q.cnt)
          TSF_EDGES_8M: s_d.st.rate = 2'h0;
          TSF_EDGES_16M: s_d.st.rate = 2'h1;
          TSF_EDGES_32M: s_d.st.rate = 2'h2;
          TSF_EDGES_65M: s_d.st.rate = 2'h3;
          default: s_d.st.rate_ok = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat_o = s_q.st;
endmodule : tsf_ref_tracker
`default_nettype wire

// *** tsf_frontend.sv ***
// Summary of operation
// - Groups three, four only at 16/8 Mbps
// - Group two output unused at 65 Mbps
// - Group one outputs run at global rate
// - Per-group inversion of input and output data
// - Unused output groups held high impedance
// - Master clock rate from two select pins
// - Per-clock rising or falling active edge
// - Master frame pulse aligns every frame
// - Per-frame-pulse active high or low
// - Reference clock rate detected automatically
// - Each reference has its own frame pulse
// - Select 00/01/10/11 gives 8/16/32/65 MHz
// - Drive gate low tristates all outputs
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`default_nettype none
module tsf_frontend
  import tsf_pkg::*;
#(
  parameter int N = 32
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_tdm_clock_i,
  input wire logic master_frame_pulse_i,
  input wire logic [1:0] alt_reference_clocks_i,
  input wire logic [1:0] alt_reference_frame_pulses_i,
  input wire logic [1:0] master_clock_rate_select_i,
  input wire logic output_drive_gate_i,
  input wire logic [N-1:0] serial_in_group_one_i,
  input wire logic [N-1:0] serial_in_group_two_i,
  input wire logic [N-1:0] serial_in_group_three_i,
  input wire logic [N-1:0] serial_in_group_four_i,
  output logic [N-1:0] serial_out_group_one_o,
  output logic [N-1:0] serial_out_group_two_o,
  output logic [N-1:0] serial_out_group_three_o,
  output logic [N-1:0] serial_out_group_four_o,
  output logic [3:0] serial_out_oe_o,
  input wire logic [3:0][N-1:0] core_out_bits_i,
  output logic [3:0][N-1:0] core_in_bits_o,
  output logic bit_strobe_o,
  output logic frame_start_o
);
  typedef struct packed {
    logic [1:0] rate;
    logic [7:0] inv;
    logic [2:0] edge_fall;
    logic [2:0] fp_low;
    logic [2:0] seen;
    logic ack;
    logic [31:0] rdat;
    logic [1:0][1:0] sel_s;
    logic [1:0] gate_s;
    logic [1:0][3:0][N-1:0] din_s;
    logic [3:0] div;
    logic [3:0][N-1:0] in_bits;
    logic [3:0][N-1:0] out_bits;
    logic [3:0] oe;
    logic strobe;
    logic frame;
  } tsf_fe_t;

  tsf_fe_t s_q, s_d;
  tsf_ref_stat_t ref_st [3];
  logic [2:0] ref_clk_w, ref_fp_w;
  logic [3:0] act_w;
  logic [1:0] ridx_w;
  logic [3:0] span_w;
  logic [3:0][N-1:0] pin_in_w;
  logic wr_w, rd_w;

  assign ref_clk_w = {alt_reference_clocks_i, master_tdm_clock_i};
  assign ref_fp_w = {alt_reference_frame_pulses_i, master_frame_pulse_i};
  assign pin_in_w = {serial_in_group_four_i, serial_in_group_three_i,
                     serial_in_group_two_i, serial_in_group_one_i};

  // ==========================================
  // Clock and frame pulse trackers
  for (genvar g = 0; g < 3; g++) begin : g_ref
    tsf_ref_tracker u_trk (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .ref_clk_i(ref_clk_w[g]),
      .ref_fp_i(ref_fp_w[g]),
      .fall_edge_i(s_q.edge_fall[g]),
      .fp_low_i(s_q.fp_low[g]),
      .stat_o(ref_st[g])
    );
  end

  // ==========================================
  // Group activity and bit span
  always_comb begin
    act_w[0] = 1'b1;
    act_w[1] = (s_q.rate != TSF_RATE_65M);
    act_w[2] = (s_q.rate != TSF_RATE_65M) && (s_q.rate != TSF_RATE_32M);
    act_w[3] = act_w[2];
    // Rate index 0 is 8.192, matching the select pin coding
    ridx_w = 2'h3 - s_q.rate;
    // Master edges per bit: clock rate over data rate, at least one
    if (s_q.sel_s[1] > ridx_w) begin
      span_w = 4'h1 << (s_q.sel_s[1] - ridx_w);
    end else begin
      span_w = 4'h1;
    end
  end

  assign wr_w = wb_cyc_i & wb_stb_i & wb_we_i & ~s_q.ack;
  assign rd_w = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_q.ack;

  // ==========================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sel_s = {s_q.sel_s[0], master_clock_rate_select_i};
    s_d.gate_s = {s_q.gate_s[0], output_drive_gate_i};
    s_d.din_s = {s_q.din_s[0], pin_in_w};
    s_d.strobe = 1'b0;
    s_d.frame = 1'b0;

    // Sticky frame seen flags; a new frame wins over the clear
    if (wr_w && (wb_adr_i == TSF_REG_STAT) && wb_sel_i[1]) begin
      s_d.seen = s_q.seen & ~wb_dat_i[TSF_STAT_SEEN_LSB +: 3];
    end
    for (int g = 0; g < 3; g++) begin
      if (ref_st[g].frame_p) begin
        s_d.seen[g] = 1'b1;
      end
    end

    // Bus slave
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
    if (wr_w) begin
      case (wb_adr_i)
        TSF_REG_RATE: begin
          if (wb_sel_i[0]) begin
            s_d.rate = wb_dat_i[1:0];
          end
        end
        TSF_REG_INV: begin
          if (wb_sel_i[0]) begin
            s_d.inv = wb_dat_i[7:0];
          end
        end
        TSF_REG_CLKC: begin
          if (wb_sel_i[0]) begin
            s_d.edge_fall = wb_dat_i[TSF_CLKC_EDGE_LSB +: 3];
            s_d.fp_low = wb_dat_i[TSF_CLKC_FPLOW_LSB +: 3];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_w) begin
      s_d.rdat = 32'h0000_0000;
      case (wb_adr_i)
        TSF_REG_RATE: s_d.rdat[1:0] = s_q.rate;
        TSF_REG_INV: s_d.rdat[7:0] = s_q.inv;
        TSF_REG_CLKC: begin
          s_d.rdat[TSF_CLKC_EDGE_LSB +: 3] = s_q.edge_fall;
          s_d.rdat[TSF_CLKC_FPLOW_LSB +: 3] = s_q.fp_low;
        end
        TSF_REG_STAT: begin
          s_d.rdat[TSF_STAT_SEL_LSB +: 2] = s_q.sel_s[1];
          s_d.rdat[TSF_STAT_ALT1_LSB +: 2] = ref_st[1].rate;
          s_d.rdat[TSF_STAT_ALT2_LSB +: 2] = ref_st[2].rate;
          s_d.rdat[TSF_STAT_SEEN_LSB +: 3] = s_q.seen;
          s_d.rdat[TSF_STAT_ACT_LSB +: 4] = act_w;
          s_d.rdat[TSF_STAT_GATE_LSB] = s_q.gate_s[1];
        end
        default: s_d.rdat = 32'h0000_0000;
      endcase
    end

    // Bit timing on master active edge, realigned by frame pulse
    if (ref_st[0].edge_p) begin
      if (ref_st[0].frame_p) begin
        s_d.div = 4'h1;
        s_d.frame = 1'b1;
        s_d.strobe = 1'b1;
      end else if (s_q.div >= span_w) begin
        s_d.div = 4'h1;
        s_d.strobe = 1'b1;
      end else begin
        s_d.div = s_q.div + 4'h1;
      end
    end

    // Sample inputs and launch outputs once per bit
    if (s_d.strobe) begin
      for (int g = 0; g < 4; g++) begin
        if (act_w[g]) begin
          s_d.in_bits[g] = s_q.din_s[1][g] ^ {N{s_q.inv[TSF_INV_IN_LSB + g]}};
          s_d.out_bits[g] = core_out_bits_i[g] ^ {N{s_q.inv[TSF_INV_OUT_LSB + g]}};
        end else begin
          s_d.in_bits[g] = '0;
          s_d.out_bits[g] = '0;
        end
      end
    end

    // Drive enables: gate pin and group activity
    for (int g = 0; g < 4; g++) begin
      s_d.oe[g] = s_q.gate_s[1] & act_w[g];
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.rate <= TSF_RATE_RST;
      s_q.inv <= TSF_INV_RST;
      s_q.edge_fall <= TSF_EDGE_RST;
      s_q.fp_low <= TSF_FPLOW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign serial_out_group_one_o = s_q.out_bits[0];
  assign serial_out_group_two_o = s_q.out_bits[1];
  assign serial_out_group_three_o = s_q.out_bits[2];
  assign serial_out_group_four_o = s_q.out_bits[3];
  assign serial_out_oe_o = s_q.oe;
  assign core_in_bits_o = s_q.in_bits;
  assign bit_strobe_o = s_q.strobe;
  assign frame_start_o = s_q.frame;
endmodule : tsf_frontend
`default_nettype wire

// *** tsf_frontend_monitor.sv ***
`default_nettype none
// ==========================================
// Port checker
module tsf_frontend_monitor
  import tsf_pkg::*;
#(
  parameter int N = 32
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic output_drive_gate_i,
  input wire logic [3:0] serial_out_oe_o,
  input wire logic [3:0][N-1:0] core_in_bits_o,
  input wire logic bit_strobe_o,
  input wire logic frame_start_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_gate_off;
    (!output_drive_gate_i) [*4];
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_grp_pair: assert property (serial_out_oe_o[2] == serial_out_oe_o[3])
    else $error("groups three and four differ");
  a_grp_nest: assert property (serial_out_oe_o[2] |-> serial_out_oe_o[1])
    else $error("group two off with group three on");
  a_grp_base: assert property (serial_out_oe_o[1] |-> serial_out_oe_o[0])
    else $error("group one off with group two on");
  a_gate_off: assert property (s_gate_off |-> serial_out_oe_o == 4'h0)
    else $error("outputs driven with gate low");
  a_frame_strobe: assert property (frame_start_o |-> bit_strobe_o)
    else $error("frame start without strobe");
  a_strobe_gap: assert property (bit_strobe_o |=> (!bit_strobe_o) [*3])
    else $error("strobes too close");
  a_in_hold: assert property ($changed(core_in_bits_o[0]) |-> bit_strobe_o)
    else $error("input bits changed between strobes");
endmodule // tsf_frontend_monitor
bind tsf_frontend tsf_frontend_monitor #(.N(N)) u_mon (
  .mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .output_drive_gate_i(output_drive_gate_i),
  .serial_out_oe_o(serial_out_oe_o),
  .core_in_bits_o(core_in_bits_o),
  .bit_strobe_o(bit_strobe_o),
  .frame_start_o(frame_start_o)
);
`default_nettype wire

// *** tsf_tdm_partner.sv ***
`default_nettype none
// ==========================================
// Free running TDM clock and frame source
module tsf_tdm_partner #(
  parameter int HALF = 4,
  parameter int EDGES = 1024
) (
  input wire logic mclk_i,
  output logic ck_o,
  output logic fp_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int per = 0;
  initial ck_o = 1'b0;
  initial fp_n_o = 1'b1;
  always @(posedge mclk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      ck_o <= ~ck_o;
      if (ck_o) begin
        per <= (per == EDGES - 1) ? 0 : per + 1;
        fp_n_o <= per != EDGES - 1;
      end
    end
  end
endmodule // tsf_tdm_partner
`default_nettype wire

// *** tsf_tb.sv ***
`default_nettype none
// ==========================================
// Testbench
module testbench
  import tsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  wire logic master_tdm_clock_i;
  wire logic master_frame_pulse_i;
  wire logic [1:0] alt_reference_clocks_i;
  wire logic [1:0] alt_reference_frame_pulses_i;
  logic [1:0] master_clock_rate_select_i = 2'h0;
  logic output_drive_gate_i = 1'b1;
  logic [31:0] serial_in_group_one_i = 32'hA5A5_0F0F;
  wire logic [31:0] serial_in_group_two_i = ~serial_in_group_one_i;
  wire logic [31:0] serial_in_group_three_i = ~serial_in_group_one_i;
  wire logic [31:0] serial_in_group_four_i = ~serial_in_group_one_i;
  logic [31:0] serial_out_group_one_o, serial_out_group_two_o;
  logic [31:0] serial_out_group_three_o, serial_out_group_four_o;
  logic [3:0] serial_out_oe_o;
  logic [3:0][31:0] core_out_bits_i = {32'hC3C3_3C3C, 32'h0F0F_F0F0, 32'h5A5A_A5A5,
                                       32'h1234_5678};
  logic [3:0][31:0] core_in_bits_o;
  logic bit_strobe_o, frame_start_o;
  int fail_count = 0;
  int cmp_count = 0;
  always #12.5 mclk_i = ~mclk_i;
  tsf_frontend dut (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .master_tdm_clock_i(master_tdm_clock_i),
    .master_frame_pulse_i(master_frame_pulse_i),
    .alt_reference_clocks_i(alt_reference_clocks_i),
    .alt_reference_frame_pulses_i(alt_reference_frame_pulses_i),
    .master_clock_rate_select_i(master_clock_rate_select_i),
    .output_drive_gate_i(output_drive_gate_i),
    .serial_in_group_one_i(serial_in_group_one_i),
    .serial_in_group_two_i(serial_in_group_two_i),
    .serial_in_group_three_i(serial_in_group_three_i),
    .serial_in_group_four_i(serial_in_group_four_i),
    .serial_out_group_one_o(serial_out_group_one_o),
    .serial_out_group_two_o(serial_out_group_two_o),
    .serial_out_group_three_o(serial_out_group_three_o),
    .serial_out_group_four_o(serial_out_group_four_o),
    .serial_out_oe_o(serial_out_oe_o),
    .core_out_bits_i(core_out_bits_i),
    .core_in_bits_o(core_in_bits_o),
    .bit_strobe_o(bit_strobe_o),
    .frame_start_o(frame_start_o)
  );
  tsf_tdm_partner u_mst (.mclk_i(mclk_i), .ck_o(master_tdm_clock_i),
    .fp_n_o(master_frame_pulse_i));
  tsf_tdm_partner #(.HALF(3), .EDGES(2048)) u_ref (.mclk_i(mclk_i),
    .ck_o(alt_reference_clocks_i[0]), .fp_n_o(alt_reference_frame_pulses_i[0]));
  assign alt_reference_clocks_i[1] = master_tdm_clock_i;
  assign alt_reference_frame_pulses_i[1] = master_frame_pulse_i;
  // ==========================================
  // Shared tasks
  task automatic finish_test;
    $display("Counts: %0d mismatches, %0d comparisons", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo(input string nm);
    fail_count++;
    $display("ERROR %s expected done seen timeout", nm);
    finish_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) tmo("bus ack");
  endtask
  task automatic next_strobe(output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (bit_strobe_o !== 1'b1 && n < 300);
    if (bit_strobe_o !== 1'b1) tmo("bit strobe");
  endtask
  task automatic wait_strobe(input int k);
    int n;
    repeat (k) next_strobe(n);
  endtask
  task automatic pin_wait(input bit fp, input logic v, input int lim);
    int n;
    n = 0;
    while ((fp ? master_frame_pulse_i : master_tdm_clock_i) !== v && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    if ((fp ? master_frame_pulse_i : master_tdm_clock_i) !== v) tmo("pin level");
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, TSF_REG_RATE, 32'h0000_0000, q);
    chk("rate reset", 32'h0000_0003, q);
    wb(1'b0, TSF_REG_INV, 32'h0000_0000, q);
    chk("inv reset", 32'h0000_0000, q);
    wb(1'b0, TSF_REG_CLKC, 32'h0000_0000, q);
    chk("clkc reset", 32'h0000_0070, q);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h40, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
  endtask
  task automatic t_rate;
    logic [31:0] q;
    int n;
    master_clock_rate_select_i <= 2'h3;
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, TSF_REG_RATE, 32'(r), q);
      wait_strobe(3);
      next_strobe(n);
      chk("bit period", 32'(8 << r), 32'(n));
      chk("groups", {r > 1, r > 1, r > 0, 1'b1}, serial_out_oe_o);
      chk("out four", r > 1 ? core_out_bits_i[3] : 0, serial_out_group_four_o);
      chk("out two", r > 0 ? core_out_bits_i[1] : 0, serial_out_group_two_o);
    end
  endtask
  task automatic t_inv;
    logic [31:0] q;
    logic [31:0] m;
    for (int i = 0; i < 2; i++) begin
      m = i ? 32'hFFFF_FFFF : 32'h0000_0000;
      wb(1'b1, TSF_REG_INV, m & 32'h0000_0099, q);
      wait_strobe(3);
      chk("in one", serial_in_group_one_i ^ m, core_in_bits_o[0]);
      chk("in four", serial_in_group_four_i ^ m, core_in_bits_o[3]);
      chk("out one", core_out_bits_i[0] ^ m, serial_out_group_one_o);
      chk("out four", core_out_bits_i[3] ^ m, serial_out_group_four_o);
      chk("in two", serial_in_group_two_i, core_in_bits_o[1]);
      chk("out three", core_out_bits_i[2], serial_out_group_three_o);
    end
  endtask
  task automatic t_gate;
    output_drive_gate_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk("oe gated", 32'h0000_0000, serial_out_oe_o);
    output_drive_gate_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk("oe open", 32'h0000_000F, serial_out_oe_o);
  endtask
  task automatic t_stat;
    logic [31:0] q;
    master_clock_rate_select_i <= 2'h1;
    repeat (26000) @(posedge mclk_i);
    wb(1'b0, TSF_REG_STAT, 32'h0000_0000, q);
    chk("select", 32'h0000_0001, q[1:0]);
    chk("ref one rate", 32'h0000_0001, q[5:4]);
    chk("ref two rate", 32'h0000_0000, q[7:6]);
    chk("frames seen", 32'h0000_0007, q[10:8]);
    wb(1'b1, TSF_REG_STAT, 32'h0000_0700, q);
    wb(1'b0, TSF_REG_STAT, 32'h0000_0000, q);
    chk("ref one cleared", 32'h0000_0000, q[9]);
  endtask
  task automatic t_edge;
    logic [31:0] q;
    int n;
    wb(1'b1, TSF_REG_RATE, 32'h0000_0002, q);
    for (int f = 0; f < 2; f++) begin
      wb(1'b1, TSF_REG_CLKC, 32'h0000_0070 | 32'(f), q);
      wait_strobe(2);
      pin_wait(1'b0, 1'b0, 20);
      pin_wait(1'b0, 1'b1, 20);
      next_strobe(n);
      chk("edge delay", f ? 32'd8 : 32'd4, 32'(n));
    end
  endtask
  task automatic t_frame;
    logic [31:0] q;
    int n;
    int k;
    for (int f = 0; f < 2; f++) begin
      wb(1'b1, TSF_REG_CLKC, f ? 32'h0000_0060 : 32'h0000_0070, q);
      pin_wait(1'b1, 1'b1, 20);
      pin_wait(1'b1, 1'b0, 9000);
      n = 0;
      do begin
        @(posedge mclk_i);
        n++;
      end while (frame_start_o !== 1'b1 && n < 40);
      chk("frame phase", f ? 32'd16 : 32'd8, 32'(n));
    end
    k = 0;
    do begin
      next_strobe(n);
      k++;
    end while (frame_start_o !== 1'b1 && k < 1100);
    chk("strobes per frame", 32'd1024, 32'(k));
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_rate();
    t_inv();
    t_gate();
    t_stat();
    t_edge();
    t_frame();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
